// ==== include/nand_host_map.vh ====
/*
 * Constants for the NAND host sequencer: AXI4-Lite register offsets,
 * field positions, command codes and pin timing counts.
 * Assumes a 200 MHz aclk; included by bare name with the include path set.
 */
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_COL         8'h04
`define REG_ROW         8'h08
`define REG_STATUS      8'h0C
`define REG_ID_LO       8'h10
`define REG_ID_HI       8'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     1
`define CTRL_OP_MSB     2
`define CTRL_CHIP_BIT   3
`define CTRL_CMD_LSB    8
`define CTRL_CMD_MSB    15

`define OP_READ_ID      2'h0
`define OP_STATUS_ENH   2'h1
`define OP_STATUS       2'h2
`define OP_ADDR5        2'h3

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_IDMODE_BIT 2
`define STAT_RB_BIT     3
`define STAT_BYTE_LSB   8

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_READ_ID     8'h90
`define CMD_ID_ADDR     8'h00
`define CMD_DUMMY       8'h00
`define CMD_STATUS      8'h70
`define CMD_STATUS_ENH  8'h78

// ----------------------------------------------------------------------
// Fifth ID byte fields
// ----------------------------------------------------------------------
`define ID5_ECC_LSB     0
`define ID5_PLN_LSB     2
`define ID5_PSZ_LSB     4
`define ID5_RSV_BIT     7

// ----------------------------------------------------------------------
// Pin timing: each strobe phase lasts this many aclk cycles
// ----------------------------------------------------------------------
`define STROBE_NS       25
`define CLK_NS          5
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define ID_BYTES        5

`endif

// ==== verilog/nand_addr_pack.v ====
/*
 * Packs column and row address into the five address bytes.
 * Assumes col and row are held stable while idx is stepped.
 */
`timescale 1ns/100ps
module nand_addr_pack (
	input  wire [11:0] col,
	input  wire [19:0] row,
	input  wire [2:0]  idx,
	output reg  [7:0]  addr_byte
);
	// Row = block field, plane bit, page field (high to low)
	always @* begin
		if (idx == 3'h0) begin
			addr_byte = col[7:0];
		end else if (idx == 3'h1) begin
			addr_byte = {4'h0, col[11:8]};
		end else if (idx == 3'h2) begin
			addr_byte = row[7:0];
		end else if (idx == 3'h3) begin
			addr_byte = row[15:8];
		end else begin
			addr_byte = {4'h0, row[19:16]};
		end
	end
endmodule

// ==== verilog/strobe_timer.v ====
/*
 * Phase timer: one-cycle tick every STROBE_CYC cycles while run is high.
 * Assumes one aclk domain, synchronous active-low reset.
 */
`timescale 1ns/100ps
`include "nand_host_map.vh"
module strobe_timer #(
	parameter CYC = `STROBE_CYC
) (
	input  wire aclk,
	input  wire aresetn,
	input  wire run,
	output reg  tick
);
	reg [7:0] cnt_r;

	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= 8'h00;
			tick  <= 1'b0;
		end else if (cnt_r == CYC[7:0] - 8'h01) begin
			cnt_r <= 8'h00;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			tick  <= 1'b0;
		end
	end
endmodule

// ==== verilog/nand_host.v ====
/*
 * Host-side NAND sequencer: AXI4-Lite registers order command, address
 * and read-ID/status sequences onto the 8-bit multiplexed flash bus.
 * Assumes the flash pins are buffered outside; io is split in/out/oe.
 */
`timescale 1ns/100ps
`include "nand_host_map.vh"
module nand_host (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [1:0]  chip_sel_n,
	output reg         cmd_latch,
	output reg         addr_latch,
	output reg         write_strobe_n,
	output reg         read_strobe_n,
	output reg         write_protect_n,
	input  wire        ready_busy_n,
	input  wire [7:0]  io_in,
	output reg  [7:0]  io_out,
	output reg         io_oe
);
	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam S_IDLE = 7'b0000001;
	localparam S_WAIT = 7'b0000010;
	localparam S_CMD  = 7'b0000100;
	localparam S_ADDR = 7'b0001000;
	localparam S_READ = 7'b0010000;
	localparam S_PRE  = 7'b0100000;
	localparam S_DONE = 7'b1000000;

	reg [6:0]  state_r;
	reg        phase_r;
	reg [2:0]  idx_r;
	reg [2:0]  n_addr_r;
	reg [2:0]  n_read_r;
	reg        dummy_r;
	reg        id_mode_r;
	reg        done_r;
	reg [1:0]  op_r;
	reg        chip_r;
	reg [7:0]  cmd_r;
	reg [11:0] col_r;
	reg [19:0] row_r;
	reg [7:0]  id_r [0:4];
	reg [7:0]  last_byte_r;
	reg [7:0]  io_s1_r;
	reg [7:0]  io_s2_r;
	reg        rb_s1_r;
	reg        rb_s2_r;
	reg        aw_hold_r;
	reg        w_hold_r;
	reg [7:0]  aw_addr_r;
	reg [31:0] w_data_r;
	reg        adv_r;
	wire [2:0] next_n;
	wire [2:0] pack_idx;
	wire       tick;
	wire [7:0] addr_byte;
	wire       go;
	integer    i;

	strobe_timer u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state_r != S_IDLE && state_r != S_DONE),
		.tick    (tick)
	);

	nand_addr_pack u_pack (
		.col       (col_r),
		.row       (row_r),
		.idx       (pack_idx),
		.addr_byte (addr_byte)
	);

	// ------------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			io_s1_r <= 8'h00;
			io_s2_r <= 8'h00;
			rb_s1_r <= 1'b0;
			rb_s2_r <= 1'b0;
		end else begin
			io_s1_r <= io_in;
			io_s2_r <= io_s1_r;
			rb_s1_r <= ready_busy_n;
			rb_s2_r <= rb_s1_r;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------------
	assign go = aw_hold_r && w_hold_r && !s_axi_bvalid && aw_addr_r == `REG_CTRL
		&& w_data_r[`CTRL_GO_BIT] && state_r == S_IDLE;

	// Index of the address cycle that goes out next
	assign next_n   = (state_r == S_CMD) ? 3'h0 : idx_r + 3'h1;
	// Status row bytes follow the two column bytes in the packer
	assign pack_idx = (op_r == `OP_STATUS_ENH) ? next_n + 3'h2 : next_n;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0;
			op_r          <= 2'h0;
			chip_r        <= 1'b0;
			cmd_r         <= 8'h00;
			col_r         <= 12'h000;
			row_r         <= 20'h00000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r     <= s_axi_awaddr;
				aw_hold_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r     <= s_axi_wdata;
				w_hold_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// Writes while a sequence runs are held off until it finishes
			if (aw_hold_r && w_hold_r && !s_axi_bvalid && state_r == S_IDLE) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				if (aw_addr_r == `REG_CTRL) begin
					op_r   <= w_data_r[`CTRL_OP_MSB:`CTRL_OP_LSB];
					chip_r <= w_data_r[`CTRL_CHIP_BIT];
					cmd_r  <= w_data_r[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
				end else if (aw_addr_r == `REG_COL) begin
					col_r <= w_data_r[11:0];
				end else if (aw_addr_r == `REG_ROW) begin
					row_r <= w_data_r[19:0];
				end else if (aw_addr_r != `REG_STATUS && aw_addr_r != `REG_ID_LO
					&& aw_addr_r != `REG_ID_HI) begin
					s_axi_bresp <= 2'h2;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_r     <= 1'b0;
				w_hold_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read side
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			if (s_axi_araddr == `REG_CTRL) begin
				s_axi_rdata <= {16'h0, cmd_r, 4'h0, chip_r, op_r, 1'b0};
			end else if (s_axi_araddr == `REG_COL) begin
				s_axi_rdata <= {20'h0, col_r};
			end else if (s_axi_araddr == `REG_ROW) begin
				s_axi_rdata <= {12'h0, row_r};
			end else if (s_axi_araddr == `REG_STATUS) begin
				s_axi_rdata <= {16'h0, last_byte_r, 4'h0, rb_s2_r, id_mode_r, done_r,
					state_r != S_IDLE};
			end else if (s_axi_araddr == `REG_ID_LO) begin
				s_axi_rdata <= {id_r[3], id_r[2], id_r[1], id_r[0]};
			end else if (s_axi_araddr == `REG_ID_HI) begin
				// Fifth byte: ECC code, plane count code, plane size code
				s_axi_rdata <= {13'h0, id_r[4][6:`ID5_PSZ_LSB],
					2'h0, id_r[4][3:`ID5_PLN_LSB], 2'h0, id_r[4][1:`ID5_ECC_LSB],
					id_r[4]};
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Flash sequencer
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r         <= S_IDLE;
			phase_r         <= 1'b0;
			adv_r           <= 1'b0;
			idx_r           <= 3'h0;
			n_addr_r        <= 3'h0;
			n_read_r        <= 3'h0;
			dummy_r         <= 1'b0;
			id_mode_r       <= 1'b0;
			done_r          <= 1'b0;
			last_byte_r     <= 8'h00;
			chip_sel_n      <= 2'b11;
			cmd_latch       <= 1'b0;
			addr_latch      <= 1'b0;
			write_strobe_n  <= 1'b1;
			read_strobe_n   <= 1'b1;
			write_protect_n <= 1'b0;
			io_out          <= 8'h00;
			io_oe           <= 1'b0;
			for (i = 0; i < `ID_BYTES; i = i + 1) begin
				id_r[i] <= 8'h00;
			end
		end else begin
			case (state_r)
			S_IDLE: begin
				chip_sel_n <= 2'b11;
				io_oe      <= 1'b0;
				if (go) begin
					done_r   <= 1'b0;
					idx_r    <= 3'h0;
					phase_r  <= 1'b0;
					// Leaving ID mode toward status needs the dummy first
					// op_r loads on this same edge, so decode the written word
					dummy_r  <= id_mode_r
						&& w_data_r[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_STATUS;
					state_r  <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (rb_s2_r) begin
					chip_sel_n <= chip_r ? 2'b01 : 2'b10;
					state_r    <= S_CMD;
					if (op_r == `OP_READ_ID) begin
						io_out   <= `CMD_READ_ID;
						n_addr_r <= 3'h1;
						n_read_r <= 3'h5;
					end else if (op_r == `OP_STATUS_ENH) begin
						io_out   <= `CMD_STATUS_ENH;
						n_addr_r <= 3'h3;
						n_read_r <= 3'h1;
					end else if (op_r == `OP_STATUS) begin
						io_out   <= dummy_r ? `CMD_DUMMY : `CMD_STATUS;
						n_addr_r <= 3'h0;
						n_read_r <= 3'h1;
					end else begin
						io_out   <= cmd_r;
						n_addr_r <= 3'h5;
						n_read_r <= 3'h0;
					end
					cmd_latch <= 1'b1;
					io_oe     <= 1'b1;
				end
			end
			S_CMD, S_ADDR: begin
				adv_r <= 1'b0;
				if (tick) begin
					phase_r        <= ~phase_r;
					write_strobe_n <= phase_r;
					// Latches and byte hold one cycle past the rising strobe
					adv_r          <= phase_r;
				end
				if (adv_r) begin
					cmd_latch  <= 1'b0;
					addr_latch <= 1'b0;
					// Any new command ends ID mode on the device side
					id_mode_r  <= (state_r == S_CMD) ? (op_r == `OP_READ_ID)
						: id_mode_r;
					if (state_r == S_CMD && dummy_r) begin
						dummy_r   <= 1'b0;
						io_out    <= `CMD_STATUS;
						cmd_latch <= 1'b1;
					end else if (next_n < n_addr_r) begin
						idx_r      <= next_n;
						state_r    <= S_ADDR;
						addr_latch <= 1'b1;
						io_out     <= (op_r == `OP_READ_ID) ? `CMD_ID_ADDR : addr_byte;
					end else begin
						idx_r   <= 3'h0;
						io_oe   <= 1'b0;
						state_r <= (n_read_r != 3'h0) ? S_PRE : S_DONE;
					end
				end
			end
			S_PRE: begin
				if (tick) begin
					state_r <= S_READ;
				end
			end
			S_READ: begin
				if (tick) begin
					phase_r       <= ~phase_r;
					read_strobe_n <= phase_r;
					if (phase_r) begin
						id_r[idx_r] <= (op_r == `OP_READ_ID) ? io_s2_r : id_r[idx_r];
						last_byte_r <= io_s2_r;
						if (idx_r + 3'h1 == n_read_r) begin
							state_r <= S_DONE;
						end else begin
							idx_r <= idx_r + 3'h1;
						end
					end
				end
			end
			default: begin
				chip_sel_n <= 2'b11;
				done_r     <= 1'b1;
				state_r    <= S_IDLE;
			end
			endcase
		end
	end

endmodule

// ==== bench/nand_host_monitor.sv ====
/* Checker for nand_host: flash pin sequencing and AXI response holding.
   Assumes it is bound onto nand_host and sees only that module's ports. */
`timescale 1ns/100ps
module nand_host_monitor (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] chip_sel_n,
	input wire logic       cmd_latch,
	input wire logic       addr_latch,
	input wire logic       write_strobe_n,
	input wire logic       read_strobe_n,
	input wire logic [7:0] io_out,
	input wire logic       io_oe
);
	logic       we_d;
	logic [7:0] last_cmd;
	logic [2:0] n_addr;
	wire        we_rise = write_strobe_n & ~we_d;
	// ----------------------------------------------------------------
	// Latched command and address count as seen at the pins
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			we_d <= 1'b1;
			last_cmd <= 8'hFF;
			n_addr <= 3'h0;
		end else begin
			we_d <= write_strobe_n;
			if (we_rise && cmd_latch) begin
				last_cmd <= io_out;
				n_addr <= 3'h0;
			end else if (we_rise && addr_latch) begin
				n_addr <= n_addr + 3'h1;
			end
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence we_low_phase;
		!write_strobe_n [*5];
	endsequence
	sequence re_low_phase;
		!read_strobe_n [*5];
	endsequence
	chk_id_addr_zero: assert property (we_rise && addr_latch && last_cmd == 8'h90
		|-> io_out == 8'h00 && n_addr == 3'h0) else $error("id address byte not zero");
	chk_col_hi_low: assert property (we_rise && addr_latch && n_addr == 3'h1 &&
		last_cmd != 8'h78 |-> io_out[7:4] == 4'h0) else $error("column byte two high bits set");
	chk_blk_hi_low: assert property (we_rise && addr_latch && n_addr == 3'h4
		|-> io_out[7:4] == 4'h0) else $error("row byte three high bits set");
	chk_addr_count: assert property (we_rise && addr_latch |-> n_addr < 3'h5)
		else $error("more than five address bytes");
	chk_dummy_first: assert property (we_rise && cmd_latch && io_out == 8'h70
		|-> last_cmd != 8'h90) else $error("status issued straight after id");
	chk_we_phase: assert property ($fell(write_strobe_n) |-> we_low_phase)
		else $error("write strobe low phase short");
	chk_re_phase: assert property ($fell(read_strobe_n) |-> re_low_phase)
		else $error("read strobe low phase short");
	chk_write_drive: assert property (!write_strobe_n |-> io_oe && chip_sel_n != 2'h3)
		else $error("write strobe without bus drive");
	chk_read_release: assert property (!read_strobe_n |-> !io_oe && chip_sel_n != 2'h3)
		else $error("bus driven during read");
	chk_one_latch: assert property (!(cmd_latch && addr_latch))
		else $error("both latch enables high");
	chk_latch_hold: assert property ($rose(write_strobe_n)
		|-> $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch))
		else $error("latch or byte moved with write strobe rise");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
endmodule

bind nand_host nand_host_monitor mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .chip_sel_n, .cmd_latch, .addr_latch, .write_strobe_n,
	.read_strobe_n, .io_out, .io_oe);

// ==== bench/nand_flash_model.sv ====
/* Behavioural flash die pair: latches commands and addresses, sources
   id and status bytes. Assumes the host drives strobes per the pins. */
`timescale 1ns/100ps
module nand_flash_model #(
	parameter logic [7:0] ID1  = 8'hA1, // Arbitrary
	parameter logic [7:0] ID2  = 8'hB2, // Arbitrary
	parameter logic [7:0] ID3  = 8'hC3, // Arbitrary
	parameter logic [7:0] ID4  = 8'hD4, // Arbitrary
	parameter logic [7:0] ID5  = 8'h66,
	parameter logic [7:0] STAT = 8'hE0
) (
	input  wire logic [1:0] chip_sel_n,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic [7:0] bus,
	output logic      [7:0] dev_q,
	output logic            ready_busy_n
);
	localparam logic [7:0] IDB [5] = '{ID1, ID2, ID3, ID4, ID5};
	logic [7:0] cmd, prev_cmd, last;
	logic [7:0] ab [5];
	logic       id_mode, die;
	int         na, ri;
	wire        sel = chip_sel_n != 2'h3;
	wire [11:0] col_addr = {ab[1][3:0], ab[0]};
	wire [19:0] row_addr = {ab[4][3:0], ab[3], ab[2]};
	initial begin
		cmd = 8'hFF;
		prev_cmd = 8'hFF;
		last = 8'h00;
		ab = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
		id_mode = 1'b0;
		die = 1'b0;
		na = 0;
		ri = 0;
		dev_q = 8'h00;
		ready_busy_n = 1'b1;
	end
	always @(posedge write_strobe_n) if (sel) begin
		if (cmd_latch) begin
			prev_cmd = cmd;
			cmd = bus;
			na = 0;
			id_mode = 1'b0;
			die = chip_sel_n[0];
		end else if (addr_latch) begin
			if (na < 5) ab[na] = bus;
			na = na + 1;
			if (cmd == 8'h90 && bus == 8'h00) begin
				id_mode = 1'b1;
				ri = 0;
			end
		end
	end
	always @(negedge read_strobe_n) if (sel) begin
		if (id_mode) begin
			last = IDB[ri % 5];
			ri = ri + 1;
		end else if (cmd == 8'h78) begin
			last = STAT ^ ab[0];
		end else begin
			last = STAT;
		end
		dev_q = last;
	end
	// Released bus shows the inverse so a stale byte is never mistaken for data
	always @(posedge read_strobe_n) dev_q = ~last;
endmodule

// ==== bench/tb_top.sv ====
/* Self-checking bench for nand_host with a behavioural flash partner.
   Assumes nand_host_map.vh on the include path and a 200 MHz aclk. */
`timescale 1ns/100ps
`include "nand_host_map.vh"
module tb_top;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, chip_sel_n;
	logic        cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_protect_n;
	logic        ready_busy_n, io_oe;
	logic [7:0]  io_out, dev_q;
	logic [1:0]  last_bresp = 2'h3;
	wire  [7:0]  io_in = io_oe ? io_out : dev_q;
	int          n_fail = 0, n_checks = 0;
	always #2.5 aclk = ~aclk;
	nand_host dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_sel_n, .cmd_latch,
		.addr_latch, .write_strobe_n, .read_strobe_n, .write_protect_n, .ready_busy_n,
		.io_in, .io_out, .io_oe);
	nand_flash_model flash (.chip_sel_n, .cmd_latch, .addr_latch, .write_strobe_n,
		.read_strobe_n, .bus(io_in), .dev_q, .ready_busy_n);
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, b_ok;
		b_ok = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 400 && !b_ok; n++) begin
			@(negedge aclk);
			aw_ok = s_axi_awvalid & s_axi_awready;
			w_ok = s_axi_wvalid & s_axi_wready;
			b_ok = s_axi_bvalid === 1'b1;
			if (b_ok) last_bresp = s_axi_bresp;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 0;
			if (w_ok) s_axi_wvalid <= 0;
			if (b_ok) s_axi_bready <= 0;
		end
		if (!b_ok) begin
			chk("write response", 1, 0);
			end_of_test;
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		r_ok = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 400 && !r_ok; n++) begin
			@(negedge aclk);
			ar_ok = s_axi_arvalid & s_axi_arready;
			r_ok = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_ok) s_axi_arvalid <= 0;
			if (r_ok) s_axi_rready <= 0;
		end
		if (!r_ok) begin
			chk("read response", 1, 0);
			end_of_test;
		end
	endtask
	// Starts one sequence and polls until done with busy clear
	task automatic run_op(input logic [1:0] op, input logic chip, input logic [7:0] c);
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr(`REG_CTRL, {16'h0, c, 4'h0, chip, op, 1'b1});
		for (int n = 0; n < 200; n++) begin
			axi_rd(`REG_STATUS, s, r);
			if (s[1:0] === 2'b10) return;
		end
		chk("sequence done", 1, 0);
		end_of_test;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_read_id;
		logic [31:0] d;
		logic [1:0]  r;
		run_op(`OP_READ_ID, 1'b0, 8'h00);
		chk("id command", 8'h90, flash.cmd);
		chk("id address count", 1, flash.na);
		axi_rd(`REG_ID_LO, d, r);
		chk("id bytes one to four", {8'hD4, 8'hC3, 8'hB2, 8'hA1}, d);
		axi_rd(`REG_ID_HI, d, r);
		chk("id byte five decode", 32'h0006_1266, d);
		axi_rd(`REG_STATUS, d, r);
		chk("id mode flag", 1, d[`STAT_IDMODE_BIT]);
	endtask
	task automatic t_status_after_id;
		logic [31:0] d;
		logic [1:0]  r;
		run_op(`OP_STATUS, 1'b0, 8'h70);
		chk("status command", 8'h70, flash.cmd);
		chk("dummy before status", 8'h00, flash.prev_cmd);
		axi_rd(`REG_STATUS, d, r);
		chk("status byte", 8'hE0, d[15:8]);
	endtask
	task automatic t_addr5;
		logic [19:0] row;
		for (int k = 0; k < 2; k++) begin
			row = k ? {13'h0001, 1'b1, 6'h00} : {13'h1FFF, 1'b0, 6'h3F};
			axi_wr(`REG_COL, k ? 32'h0000_0ABC : 32'h0000_0FFF);
			axi_wr(`REG_ROW, {12'h0, row});
			run_op(`OP_ADDR5, 1'b0, 8'h00);
			chk("address count", 5, flash.na);
			chk("column", k ? 12'hABC : 12'hFFF, flash.col_addr);
			chk("page field", row[5:0], flash.ab[2][5:0]);
			chk("plane bit", row[6], flash.ab[2][6]);
			chk("block field", row[19:7], {flash.ab[4][3:0], flash.ab[3], flash.ab[2][7]});
			chk("row", row, flash.row_addr);
		end
	endtask
	task automatic t_enh_status;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(`REG_ROW, {12'h0, 13'h0123, 1'b1, 6'h15});
		chk("row write response", 2'h0, last_bresp);
		run_op(`OP_STATUS_ENH, 1'b1, 8'h78);
		chk("enhanced command", 8'h78, flash.cmd);
		chk("enhanced row bytes", 3, flash.na);
		chk("second die", 1, flash.die);
		axi_rd(`REG_STATUS, d, r);
		chk("enhanced status", 8'hE0 ^ {1'b1, 1'b1, 6'h15}, d[15:8]);
	endtask
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(8'h40, d, r);
		chk("unmapped response", 2'h2, r);
		axi_wr(8'h40, 32'h0000_0001);
		chk("unmapped write response", 2'h2, last_bresp);
		chk("write protect", 1'b0, write_protect_n);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		t_read_id;
		t_status_after_id;
		t_addr5;
		t_enh_status;
		t_unmapped;
		end_of_test;
	end
endmodule
